//--- src/mrs_pkg.sv
package mrs_pkg;

   // Oscillator rate and machine-cycle length.
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned MC_OSC_PERIODS = 12;
   localparam logic [3:0]  MC_LAST        = 4'(MC_OSC_PERIODS - 1);

   // Reset pin detection: samples high on this many edges start a reset.
   localparam logic [1:0]  RST_DET_EDGES  = 2'h2;
   // Delay from valid reset to ports reset, and from release to strobes driven.
   localparam logic [1:0]  PORT_DLY       = 2'h2;
   localparam logic [1:0]  STROBE_DLY     = 2'h2;

   // Least external reset pulse, in oscillator periods (far side obligation).
   localparam int unsigned RST_MIN_PERIODS = 4;

   // Reset values.
   localparam logic [7:0]  PORT_RST       = 8'hFF;
   localparam logic [7:0]  POWER_CONTROL_REGISTER_RST       = 8'h00;
   localparam logic [15:0] PC_RST         = 16'h0000;

   // Power control register field positions.
   localparam int unsigned POWER_CONTROL_REGISTER_IDLE_BIT  = 0;
   localparam int unsigned POWER_CONTROL_REGISTER_PD_BIT    = 1;
   // Bits that exist; the power-off flag position is not among them.
   localparam logic [7:0]  POWER_CONTROL_REGISTER_IMPL_MASK = 8'h03;

   // Sequencer states.
   typedef enum logic [2:0] {
      SEQ_RUN      = 3'b000,
      SEQ_RESET    = 3'b001,
      SEQ_WAIT     = 3'b010,
      SEQ_DUMMY1   = 3'b011,
      SEQ_DUMMY2   = 3'b100
   } mrs_state_t;

   // Strobes and fetch qualifiers that go out together.
   typedef struct packed {
      logic addr_latch;
      logic program_fetch_strobe_n;
      logic fetch_discard;
      logic exec_enable;
   } mrs_bus_t;

endpackage

//--- src/mrs_reset_sequencer.sv
// How it works
// - Whole chip resets synchronously after reset seen high on 2 edges.
// - Port pins take reset state 2 periods after a valid high reset.
// - During reset fetch strobe high, latch strobe low, ports weakly high.
// - Every special function register loads its reset value on reset.
// - Internal data memory keeps its contents through reset.
// - Reset takes the device out of idle or power-down.
// - Strobes start being driven 2 periods after the chip reset falls.
// - First access after release is made but its data discarded.
// - Access repeats next machine cycle; real execution starts there.
// - One machine cycle is 12 oscillator periods.
// - Power control register holds no power-off flag.
// - Reset out of idle keeps RAM, clears registers, starts at 0.
// - Setting power control bit 0 enters idle; reset or interrupt clears it.
module mrs_reset_sequencer (
   // Clock and power-on reset.
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   // External reset pin, asynchronous, active high.
   input  wire logic                i_reset_pin,
   // Core side: power control writes and idle wakeup.
   input  wire logic                i_power_control_register_we,
   input  wire logic [7:0]          i_power_control_register_wdata,
   input  wire logic                i_irq_wake,
   // Port pin drive for one port, from the core.
   input  wire logic [7:0]          i_port_out,
   // Chip-wide synchronous reset and power state.
   output logic                     o_chip_reset,
   output logic [7:0]               o_power_control_register,
   output logic                     o_idle,
   output logic                     o_power_down,
   output logic [15:0]              o_pc_start,
   // Port pins: output, enable (low drives), weak pull-up request.
   output logic [7:0]               o_port_out,
   output logic [7:0]               o_port_oe_n,
   output logic                     o_port_weak_pullup,
   // Memory strobes and fetch qualifiers.
   output mrs_pkg::mrs_bus_t        o_bus,
   output logic                     o_strobe_oe_n
);

   // Reset pin synchroniser; only stages two and three are compared.
   // The pin is an asynchronous level from a board-level source, so the
   // first stage may go metastable; nothing reads it but the second stage.
   // Requiring stages two and three to agree also rejects a one-cycle glitch,
   // at the cost of one more period of latency before a reset is seen.
   // The filtered level keeps its old value while the two stages differ.
   logic [2:0] sync_q, sync_d;
   logic       pin_q, pin_d;

   always_comb begin
      sync_d = {sync_q[1:0], i_reset_pin};
      pin_d  = pin_q;
      if (sync_q[2] == sync_q[1]) begin
         pin_d = sync_q[2];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync_q <= 3'h0;
         pin_q  <= 1'b0;
      end else begin
         sync_q <= sync_d;
         pin_q  <= pin_d;
      end
   end

   // Sequencer: high-edge count, release delay, machine-cycle counter.
   mrs_pkg::mrs_state_t state_q, state_d;
   logic [1:0] hi_cnt_q, hi_cnt_d;
   logic [1:0] dly_q, dly_d;
   logic [1:0] port_dly_q, port_dly_d;
   logic [3:0] phase_q, phase_d;
   logic       ports_rst_q, ports_rst_d;
   logic       det;

   // A high level counts once it has been sampled on two rising edges.
   // The counter saturates, so a pin held high for a long time produces a
   // single detection pulse and the sequencer is not restarted every cycle.
   // From the pin edge to the reset state the total is three synchroniser
   // stages, the filter flop, plus the two qualifying samples.
   assign det = pin_q && (hi_cnt_q == mrs_pkg::RST_DET_EDGES - 2'h1);

   always_comb begin
      state_d     = state_q;
      hi_cnt_d    = pin_q ? hi_cnt_q : 2'h0;
      dly_d       = dly_q;
      port_dly_d  = port_dly_q;
      ports_rst_d = ports_rst_q;
      // The phase counter runs freely; the release path forces it to zero so
      // that the first discarded cycle starts on a machine-cycle boundary.
      // A free-running counter keeps the strobe rhythm steady in normal run.
      phase_d     = (phase_q == mrs_pkg::MC_LAST) ? 4'h0 : phase_q + 4'h1;
      if (pin_q && hi_cnt_q != mrs_pkg::RST_DET_EDGES) begin
         hi_cnt_d = hi_cnt_q + 2'h1;
      end
      // Port reset lags detection by a fixed count of periods.
      if (state_q == mrs_pkg::SEQ_RESET && !ports_rst_q) begin
         if (port_dly_q == mrs_pkg::PORT_DLY - 2'h1) begin
            ports_rst_d = 1'b1;
         end else begin
            port_dly_d = port_dly_q + 2'h1;
         end
      end
      // Release path: reset, a short wait, one discarded machine cycle, one
      // repeated access, then normal run. The pin must be low in the filtered
      // view before anything leaves the reset state.
      case (state_q)
         mrs_pkg::SEQ_RESET: begin
            dly_d = 2'h0;
            if (!pin_q) begin
               // Pin low again: the ports go back to the core's drive.
               state_d     = mrs_pkg::SEQ_WAIT;
               ports_rst_d = 1'b0;
            end
         end
         // Strobes stay parked for a fixed count of periods after release.
         mrs_pkg::SEQ_WAIT: begin
            dly_d = dly_q + 2'h1;
            if (dly_q == mrs_pkg::STROBE_DLY - 2'h1) begin
               state_d = mrs_pkg::SEQ_DUMMY1;
               phase_d = 4'h0;
            end
         end
         // The first machine cycle fetches, but the core drops the data.
         mrs_pkg::SEQ_DUMMY1: begin
            if (phase_q == mrs_pkg::MC_LAST) begin
               state_d = mrs_pkg::SEQ_DUMMY2;
            end
         end
         mrs_pkg::SEQ_DUMMY2: begin
            state_d = mrs_pkg::SEQ_RUN;
         end
         default: begin
            state_d = mrs_pkg::SEQ_RUN;
         end
      endcase
      // Detection wins over every other state, including low-power ones.
      // Placing it last means no earlier assignment in this process can
      // mask a reset, whatever the sequencer was doing at the time.
      if (det) begin
         state_d     = mrs_pkg::SEQ_RESET;
         ports_rst_d = 1'b0;
         port_dly_d  = 2'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_q     <= mrs_pkg::SEQ_RESET;
         hi_cnt_q    <= 2'h0;
         dly_q       <= 2'h0;
         port_dly_q  <= 2'h0;
         phase_q     <= 4'h0;
         ports_rst_q <= 1'b1;
      end else begin
         state_q     <= state_d;
         hi_cnt_q    <= hi_cnt_d;
         dly_q       <= dly_d;
         port_dly_q  <= port_dly_d;
         phase_q     <= phase_d;
         ports_rst_q <= ports_rst_d;
      end
   end

   // Decoded reset state, shared by the register clear and the chip reset.
   // It is a plain decode of a flip-flop, so it carries no glitch hazard.
   logic in_reset;
   assign in_reset = (state_q == mrs_pkg::SEQ_RESET);

   // Power control register. Only idle and power-down bits exist, so a write
   // of the power-off flag position reads back zero.
   // A write that sets the idle bit in the same cycle as a wakeup leaves idle
   // clear: the wakeup is the later event from the core's point of view.
   // Reset overrides both, so the device never stays in a low-power mode.
   logic [7:0] power_control_register_q, power_control_register_d;

   always_comb begin
      power_control_register_d = power_control_register_q;
      if (i_power_control_register_we) begin
         power_control_register_d = i_power_control_register_wdata & mrs_pkg::POWER_CONTROL_REGISTER_IMPL_MASK;
      end
      if (i_irq_wake) begin
         power_control_register_d[mrs_pkg::POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
      end
      if (in_reset) begin
         power_control_register_d = mrs_pkg::POWER_CONTROL_REGISTER_RST;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         power_control_register_q <= mrs_pkg::POWER_CONTROL_REGISTER_RST;
      end else begin
         power_control_register_q <= power_control_register_d;
      end
   end

   // Outputs from flip-flops. The chip reset is a level that the core's SFRs
   // use as their synchronous reset; internal RAM is deliberately not wired
   // to it so that its contents survive.
   mrs_pkg::mrs_bus_t bus_q, bus_d;
   logic [7:0]        port_q, port_d;
   logic              chip_rst_q, chip_rst_d;
   logic              drive_q, drive_d;
   logic              phase_al;
   logic              phase_fetch_n;

   // Strobe rhythm within one machine cycle: the latch strobe pulses at the
   // start of each half cycle and the fetch strobe is low for three periods
   // in each half, so two fetches fall in every machine cycle.
   always_comb begin
      phase_al      = (phase_q == 4'h0) || (phase_q == 4'h6);
      phase_fetch_n = !((phase_q >= 4'h2 && phase_q <= 4'h4) ||
                        (phase_q >= 4'h8 && phase_q <= 4'hA));
   end

   // Chip reset follows the reset state one period late, as a clean level.
   // The strobe pins are driven from the first discarded cycle onward and
   // released before it, so the pads never fight an external driver.
   always_comb begin
      chip_rst_d = in_reset;
      drive_d    = (state_q == mrs_pkg::SEQ_DUMMY1) ||
                   (state_q == mrs_pkg::SEQ_DUMMY2) ||
                   (state_q == mrs_pkg::SEQ_RUN);
   end

   // Bus and port next values. The port value follows the next reset flag,
   // not the current one, so the port data and its enable change on the
   // same edge and the pins never show a stale core value while released.
   always_comb begin
      bus_d.addr_latch             = 1'b0;
      bus_d.program_fetch_strobe_n = 1'b1;
      bus_d.fetch_discard          = 1'b0;
      bus_d.exec_enable            = 1'b0;
      port_d                       = i_port_out;
      if (ports_rst_d) begin
         port_d = mrs_pkg::PORT_RST;
      end
      case (state_q)
         mrs_pkg::SEQ_DUMMY1: begin
            // Six-period strobe rhythm, returned data thrown away.
            bus_d.addr_latch             = phase_al;
            bus_d.program_fetch_strobe_n = phase_fetch_n;
            bus_d.fetch_discard          = 1'b1;
         end
         // The repeated access is real: execution is enabled from here on.
         mrs_pkg::SEQ_DUMMY2, mrs_pkg::SEQ_RUN: begin
            bus_d.addr_latch             = phase_al;
            bus_d.program_fetch_strobe_n = phase_fetch_n;
            bus_d.exec_enable            = 1'b1;
         end
         default: begin
            // Reset and release delay keep strobes parked.
            bus_d.addr_latch             = 1'b0;
            bus_d.program_fetch_strobe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         bus_q      <= '{addr_latch: 1'b0, program_fetch_strobe_n: 1'b1,
                         fetch_discard: 1'b0, exec_enable: 1'b0};
         port_q     <= mrs_pkg::PORT_RST;
         chip_rst_q <= 1'b1;
         drive_q    <= 1'b0;
      end else begin
         bus_q      <= bus_d;
         port_q     <= port_d;
         chip_rst_q <= chip_rst_d;
         drive_q    <= drive_d;
      end
   end

   // Port pins float to the weak pull-up while in reset, else drive.
   // All eight pins share one enable; per-pin direction belongs to the port
   // logic of the core and is outside this block.
   assign o_port_out               = port_q;
   assign o_port_oe_n              = ports_rst_q ? 8'hFF : 8'h00;
   assign o_port_weak_pullup       = ports_rst_q;
   assign o_bus                    = bus_q;
   assign o_strobe_oe_n            = !drive_q;
   assign o_chip_reset             = chip_rst_q;
   assign o_power_control_register = power_control_register_q;
   assign o_idle                   = power_control_register_q[mrs_pkg::POWER_CONTROL_REGISTER_IDLE_BIT];
   assign o_power_down             = power_control_register_q[mrs_pkg::POWER_CONTROL_REGISTER_PD_BIT];
   // Execution always restarts from the bottom of program memory.
   assign o_pc_start               = mrs_pkg::PC_RST;

endmodule // mrs_reset_sequencer

//--- sim/mrs_reset_sequencer_props.sv
module mrs_reset_sequencer_props (
   // Clock, reset, pin, power control writes and wakeup.
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic              i_reset_pin,
   input wire logic              i_power_control_register_we,
   input wire logic [7:0]        i_power_control_register_wdata,
   input wire logic              i_irq_wake,
   // Watched outputs.
   input wire logic              o_chip_reset,
   input wire logic [7:0]        o_power_control_register,
   input wire logic              o_idle,
   input wire logic [7:0]        o_port_oe_n,
   input wire logic              o_port_weak_pullup,
   input wire mrs_pkg::mrs_bus_t o_bus,
   input wire logic              o_strobe_oe_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // A release is seen as the fall of the chip reset.
   sequence s_release;
      $fell(o_chip_reset);
   endsequence
   sequence s_pin_held;
      $rose(i_reset_pin) ##0 i_reset_pin[*4];
   endsequence

   // The pin is synchronised, so no reset may appear at once.
   a_pin_resets: assert property (s_pin_held |-> ##[4:5] o_chip_reset)
      else $error("chip reset late");
   a_no_async: assert property ($rose(i_reset_pin) && !o_chip_reset |=> !o_chip_reset[*2])
      else $error("chip reset too early");
   a_ports_follow: assert property ($rose(o_chip_reset) |-> ##1 (o_port_oe_n == 8'hFF && o_port_weak_pullup))
      else $error("ports not in reset state");
   a_strobes_parked: assert property (o_chip_reset |-> o_bus.program_fetch_strobe_n && !o_bus.addr_latch && o_strobe_oe_n && !o_bus.exec_enable)
      else $error("strobes not parked");
   a_strobe_start: assert property (s_release |-> o_strobe_oe_n ##1 o_strobe_oe_n ##1 !o_strobe_oe_n)
      else $error("strobe drive timing");
   a_discard_cycle: assert property ($rose(o_bus.fetch_discard) |-> !o_bus.exec_enable ##[11:13] $rose(o_bus.exec_enable))
      else $error("discarded cycle length");
   a_power_control_register_no_flag: assert property ((o_power_control_register & 8'hFC) == 8'h00 && o_idle == o_power_control_register[0])
      else $error("power control bits");
   a_idle_entry: assert property (i_power_control_register_we && i_power_control_register_wdata[0] && !i_irq_wake && !o_chip_reset && !i_reset_pin |=> o_idle)
      else $error("idle not entered");
   a_reset_wakes: assert property ($rose(o_chip_reset) |-> ##[0:1] (o_power_control_register[1:0] == 2'h0))
      else $error("low power kept in reset");
endmodule // mrs_reset_sequencer_props

bind mrs_reset_sequencer mrs_reset_sequencer_props u_props (.i_clk, .i_rst_n, .i_reset_pin,
   .i_power_control_register_we, .i_power_control_register_wdata, .i_irq_wake, .o_chip_reset, .o_power_control_register, .o_idle,
   .o_port_oe_n, .o_port_weak_pullup, .o_bus, .o_strobe_oe_n);

//--- sim/mrs_reset_src.sv
module mrs_reset_src (
   input  wire logic i_clk,
   output logic      o_reset_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // The pin has a pull-down, so it idles low.
   initial o_reset_pin = 1'b0;
   // Holds the pin high for whole clock periods; callers give at least 4.
   task automatic pulse(input int n);
      @(posedge i_clk);
      o_reset_pin <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_reset_pin <= 1'b0;
   endtask
endmodule // mrs_reset_src

//--- sim/mrs_reset_sequencer_test.sv
module mrs_reset_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic              i_clk;
   logic              i_rst_n;
   logic              i_reset_pin;
   logic              i_power_control_register_we;
   logic [7:0]        i_power_control_register_wdata;
   logic              i_irq_wake;
   logic [7:0]        i_port_out;
   logic              o_chip_reset;
   logic [7:0]        o_power_control_register;
   logic              o_idle;
   logic              o_power_down;
   logic [15:0]       o_pc_start;
   logic [7:0]        o_port_out;
   logic [7:0]        o_port_oe_n;
   logic              o_port_weak_pullup;
   mrs_pkg::mrs_bus_t o_bus;
   logic              o_strobe_oe_n;
   int                fail_count;
   int                n_compared;

   mrs_reset_sequencer uut (.i_clk, .i_rst_n, .i_reset_pin, .i_power_control_register_we, .i_power_control_register_wdata,
      .i_irq_wake, .i_port_out, .o_chip_reset, .o_power_control_register, .o_idle,
      .o_power_down, .o_pc_start, .o_port_out, .o_port_oe_n, .o_port_weak_pullup, .o_bus,
      .o_strobe_oe_n);
   mrs_reset_src src (.i_clk, .o_reset_pin(i_reset_pin));

   // Clock at 10 MHz.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Chip reset, ports, bus strobes and power control held in their reset state.
   task automatic t_held;
      chk("chip reset", 16'h0001, 16'(o_chip_reset));
      chk("port out", 16'h00FF, 16'(o_port_out));
      chk("port oe", 16'h00FF, 16'(o_port_oe_n));
      chk("pullup", 16'h0001, 16'(o_port_weak_pullup));
      chk("bus", 16'h0004, 16'(o_bus));
      chk("power_control_register", 16'h0000, 16'(o_power_control_register));
   endtask

   // Counts the discarded periods up to the start of execution.
   task automatic t_release;
      int n;
      int d;
      n = 0;
      d = 0;
      while (o_bus.exec_enable !== 1'b1 && n < 60) begin
         @(posedge i_clk);
         #1;
         n++;
         if (o_bus.fetch_discard === 1'b1) d++;
      end
      chk("exec", 16'h0001, 16'(o_bus.exec_enable));
      chk("discard", 16'(mrs_pkg::MC_OSC_PERIODS), 16'(d));
      chk("strobe oe", 16'h0000, 16'(o_strobe_oe_n));
      chk("pc start", 16'h0000, o_pc_start);
   endtask

   // Power control writes, wake and masked flag.
   task automatic t_power_control_register;
      i_port_out <= 8'h5A;
      i_power_control_register_we <= 1'b1;
      i_power_control_register_wdata <= 8'hFF;
      @(posedge i_clk);
      i_power_control_register_we <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("power_control_register all", 16'h0003, 16'(o_power_control_register));
      chk("idle", 16'h0001, 16'(o_idle));
      chk("port run", 16'h005A, 16'(o_port_out));
      @(posedge i_clk);
      i_irq_wake <= 1'b1;
      @(posedge i_clk);
      i_irq_wake <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("power_control_register wake", 16'h0002, 16'(o_power_control_register));
      chk("idle off", 16'h0000, 16'(o_idle));
      chk("power down", 16'h0001, 16'(o_power_down));
   endtask

   // A valid pin pulse while in power-down.
   task automatic t_pin_reset;
      int n;
      fork
         src.pulse(4);
      join_none
      @(posedge i_clk);
      n = 0;
      while (o_chip_reset !== 1'b1 && n < 20) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      // Three synchroniser stages, the filter flop, two qualifying samples, one output flop.
      chk("reset delay", 16'h0007, 16'(n));
      @(posedge i_clk);
      #1;
      t_held;
   endtask

   initial begin
      fail_count = 0;
      n_compared = 0;
      i_rst_n = 1'b0;
      i_power_control_register_we = 1'b0;
      i_power_control_register_wdata = 8'h00;
      i_irq_wake = 1'b0;
      i_port_out = 8'h00;
      repeat (3) @(posedge i_clk);
      #1;
      t_held;
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_release;
      @(posedge i_clk);
      t_power_control_register;
      t_pin_reset;
      t_release;
      report_and_stop;
   end

   // Cuts a hang short; the run needs well under 300 cycles.
   initial begin
      #100_000;
      fail_count++;
      report_and_stop;
   end
endmodule // mrs_reset_sequencer_test
